// file: logic/scp_params.svh
// constants for the serial command port: frame layout, timing and register reset values
// assumes inclusion by both ends and the package
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_FRAME_BITS 16
`define SCP_DIR_POS 0
`define SCP_ADDR_FIRST 1
`define SCP_ADDR_LAST 3
`define SCP_IDLE_PERIODS 4
`define SCP_DATA_FIRST 8
`define SCP_DATA_LAST 15
`define SCP_DATA_BITS 8
`define SCP_REG_BITS 5
`define SCP_REG_COUNT 8
`define SCP_REG_RESET 5'h00
`define SCP_DIR_WRITE 1'b0
`define SCP_DIR_READ 1'b1
`define SCP_GAP_NS 250
`define SCP_MCLK_NS 10
`define SCP_GAP_CYC ((`SCP_GAP_NS + `SCP_MCLK_NS - 1) / `SCP_MCLK_NS)
`define SCP_SCLK_HALF 6
`endif

// file: logic/scp_pkg.sv
// types shared by both ends of the serial command port
// assumes scp_params.svh is reachable by bare name
`include "scp_params.svh"
package scp_pkg;
  typedef logic [2:0] scp_addr_t;
  typedef logic [`SCP_REG_BITS-1:0] scp_reg_t;
  typedef logic [`SCP_DATA_BITS-1:0] scp_data_t;
  typedef enum logic [1:0] {SCP_IDLE, SCP_LEAD, SCP_SHIFT, SCP_GAP} scp_host_st_t;
endpackage

// file: logic/scp_if.sv
// link wires of the serial command port between controller and device
// assumes the bench resolves the shared data wire from the enables
`timescale 1ns/1ns
interface scp_if;
  logic sclk;
  logic port_select_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  modport dev (input sclk, input port_select_n, input serial_data_in,
    output serial_data_out, output serial_data_out_oe);
  modport host (output sclk, output port_select_n, output serial_data_in,
    input serial_data_out, input serial_data_out_oe);
endinterface

// file: logic/scp_dev.sv
// device end: receives write frames on the link clock, holds the command registers
// assumes sclk is made by the controller and may stop between frames
`timescale 1ns/1ns
`include "scp_params.svh"
module scp_dev (
  input wire logic mclk,
  input wire logic rst,
  scp_if.dev link,
  input wire scp_pkg::scp_addr_t rd_addr,
  output scp_pkg::scp_reg_t rd_data,
  output logic wr_pulse
);
  import scp_pkg::*;

  // ****************************************
  // link clock domain
  // ****************************************
  logic [4:0] bit_cnt_r;
  logic dir_r;
  scp_addr_t addr_r;
  scp_data_t data_r;
  logic done_tgl_r = 1'b0; // link side has no reset; toggle starts low
  scp_addr_t done_addr_r;
  scp_reg_t done_data_r;
  scp_reg_t regs_r [`SCP_REG_COUNT];

  // bit counter, restarted by select high so an aborted frame is forgotten
  always_ff @(posedge link.sclk or posedge link.port_select_n) begin
    if (link.port_select_n) begin
      bit_cnt_r <= 5'h00;
    end else if (bit_cnt_r < 5'h10) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // shift in direction, address and data on rising edges
  always_ff @(posedge link.sclk) begin
    if (!link.port_select_n) begin
      if (bit_cnt_r == 5'(`SCP_DIR_POS)) begin
        dir_r <= link.serial_data_in;
      end else if (bit_cnt_r <= 5'(`SCP_ADDR_LAST)) begin
        addr_r <= {link.serial_data_in, addr_r[2:1]};
      end else if (bit_cnt_r >= 5'(`SCP_DATA_FIRST) && bit_cnt_r <= 5'(`SCP_DATA_LAST)) begin
        data_r <= {link.serial_data_in, data_r[7:1]};
      end
    end
  end

  // hand a finished write to mclk by toggle; addr and data stay stable meanwhile
  always_ff @(posedge link.sclk) begin
    if (!link.port_select_n && bit_cnt_r == 5'(`SCP_DATA_LAST)
        && dir_r == `SCP_DIR_WRITE) begin
      done_addr_r <= addr_r;
      done_data_r <= data_r[5:1]; // d0..d4 after seven shifts; d7 is on the pin now
      done_tgl_r <= ~done_tgl_r;
    end
  end

  // output is never driven: read path not built here
  assign link.serial_data_out = 1'b0;
  assign link.serial_data_out_oe = 1'b0;

  // ****************************************
  // system clock domain
  // ****************************************
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;

  // toggle synchroniser and edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= done_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // command registers, written once per completed write frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `SCP_REG_COUNT; i++) begin
        regs_r[i] <= `SCP_REG_RESET;
      end
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= tgl_s2_r ^ tgl_s3_r;
      if (tgl_s2_r ^ tgl_s3_r) begin
        regs_r[done_addr_r] <= done_data_r;
      end
    end
  end

  // registered view of one command register
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= `SCP_REG_RESET;
    end else begin
      rd_data <= regs_r[rd_addr];
    end
  end
endmodule // scp_dev

// file: logic/scp_host.sv
// controller end: sends write frames, makes sclk by dividing mclk
// assumes the user holds wr_addr and wr_data while wr_ready is low
`timescale 1ns/1ns
`include "scp_params.svh"
module scp_host (
  input wire logic mclk,
  input wire logic rst,
  scp_if.host link,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire scp_pkg::scp_addr_t wr_addr,
  input wire scp_pkg::scp_reg_t wr_data
);
  import scp_pkg::*;

  // ****************************************
  // frame sequencer
  // ****************************************
  scp_host_st_t st_r;
  logic [3:0] div_r;
  logic [4:0] bit_r;
  logic [15:0] frame_r;
  logic [5:0] gap_r;

  assign wr_ready = (st_r == SCP_IDLE);

  // sclk divider runs in lead and shift; toggles at div wrap
  always_ff @(posedge mclk) begin
    if (rst || st_r == SCP_IDLE || st_r == SCP_GAP) begin
      div_r <= 4'h0;
      link.sclk <= 1'b0;
    end else if (div_r == 4'(`SCP_SCLK_HALF - 1)) begin
      div_r <= 4'h0;
      link.sclk <= ~link.sclk;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // frame state, select and data output
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= SCP_IDLE;
      link.port_select_n <= 1'b1;
      link.serial_data_in <= 1'b0;
      bit_r <= 5'h00;
      frame_r <= 16'h0000;
      gap_r <= 6'h00;
    end else begin
      case (st_r)
        SCP_IDLE: begin
          if (wr_valid) begin
            // dir, addr lsb first, idle, data lsb first with top bits zero
            frame_r <= {3'h0, wr_data, 4'h0, wr_addr, `SCP_DIR_WRITE};
            st_r <= SCP_LEAD;
          end
        end
        SCP_LEAD: begin
          // one clock period runs before select falls with sclk
          if (link.sclk && div_r == 4'(`SCP_SCLK_HALF - 1)) begin
            link.port_select_n <= 1'b0;
            link.serial_data_in <= frame_r[0];
            bit_r <= 5'h00;
            st_r <= SCP_SHIFT;
          end
        end
        SCP_SHIFT: begin
          if (link.sclk && div_r == 4'(`SCP_SCLK_HALF - 1)) begin
            if (bit_r == 5'(`SCP_FRAME_BITS - 1)) begin
              link.port_select_n <= 1'b1;
              gap_r <= 6'h00;
              st_r <= SCP_GAP;
            end else begin
              bit_r <= bit_r + 5'h01;
              link.serial_data_in <= frame_r[4'(bit_r + 5'h01)];
            end
          end
        end
        SCP_GAP: begin
          gap_r <= gap_r + 6'h01;
          if (gap_r == 6'(`SCP_GAP_CYC)) begin
            st_r <= SCP_IDLE;
          end
        end
        default: st_r <= SCP_IDLE;
      endcase
    end
  end
endmodule // scp_host

// file: verif/scp_chk_sva.sv
// checker for the serial command link, timed on mclk
// assumes the host makes sclk and select from mclk
`timescale 1ns/1ns
module scp_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  logic [7:0] run_r;
  logic [4:0] nb_r;
  logic sel_q_r, sclk_q_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since select last changed, saturating
  always_ff @(posedge mclk) begin
    sel_q_r <= rst | port_select_n;
    if (rst) run_r <= 8'hFF;
    else if (port_select_n != sel_q_r) run_r <= 8'h01;
    else if (run_r != 8'hFF) run_r <= run_r + 8'h01;
  end
  // sclk rises seen inside the frame
  always_ff @(posedge mclk) begin
    sclk_q_r <= sclk;
    if (rst || port_select_n) nb_r <= 5'h00;
    else if (sclk && !sclk_q_r) nb_r <= nb_r + 5'h01;
  end
  // ********
  // link rules
  // ********
  sequence s_dir; !serial_data_in ##6 ($rose(sclk) && !serial_data_in); endsequence
  sequence s_half; $stable(sclk)[*5] ##1 $fell(sclk); endsequence
  property p_oe; !serial_data_out_oe; endproperty
  a_oe: assert property (p_oe) else $error("sdo driven");
  property p_start; $fell(port_select_n) |-> $fell(sclk); endproperty
  a_start: assert property (p_start) else $error("select off sclk fall");
  property p_dir; $fell(port_select_n) |-> s_dir; endproperty
  a_dir: assert property (p_dir) else $error("bad direction bit");
  property p_half; $rose(sclk) && !port_select_n |=> s_half; endproperty
  a_half: assert property (p_half) else $error("bad sclk high time");
  property p_idle; $rose(sclk) && !port_select_n &&
    nb_r inside {[5'h04:5'h07], [5'h0D:5'h0F]} |-> !serial_data_in; endproperty
  a_idle: assert property (p_idle) else $error("idle or top bit set");
  property p_len; $rose(port_select_n) |-> run_r == 8'hC0; endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_bits; $rose(port_select_n) |-> nb_r == 5'h10; endproperty
  a_bits: assert property (p_bits) else $error("bit count wrong");
  property p_gap; $fell(port_select_n) |-> run_r >= 8'h19; endproperty
  a_gap: assert property (p_gap) else $error("gap too short");
endmodule // scp_chk

// file: verif/tb_serial_control_port_write.sv
// bench: host and device joined, plus a second device driven by hand
// assumes the design ends and the checker are compiled first
`timescale 1ns/1ns
module tb_serial_control_port_write;
  import scp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr_valid = 1'b0;
  logic wr_ready, wr_pulse, wr_pulse2;
  scp_addr_t wr_addr = 3'h0;
  scp_addr_t rd_addr = 3'h0;
  scp_reg_t wr_data = 5'h00;
  scp_reg_t rd_data, rd_data2;
  int errors = 0;
  int n_compared = 0;
  int n_p2 = 0;
  scp_if link ();
  scp_if link2 ();
  always #5 mclk = ~mclk;
  scp_host scp_host_inst (.mclk(mclk), .rst(rst), .link(link), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
  scp_dev scp_dev_inst (.mclk(mclk), .rst(rst), .link(link), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_pulse(wr_pulse));
  scp_dev scp_dev_inst2 (.mclk(mclk), .rst(rst), .link(link2), .rd_addr(rd_addr),
    .rd_data(rd_data2), .wr_pulse(wr_pulse2));
  scp_chk scp_chk_inst (.mclk(mclk), .rst(rst), .sclk(link.sclk),
    .port_select_n(link.port_select_n), .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out), .serial_data_out_oe(link.serial_data_out_oe));
  // ********
  // tasks
  // ********
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input scp_addr_t a, input scp_reg_t exp);
    @(posedge mclk) rd_addr <= a;
    repeat (2) @(posedge mclk);
    @(negedge mclk) chk("rd_data", exp, rd_data);
  endtask
  task automatic wr(input scp_addr_t a, input scp_reg_t d);
    int i;
    for (i = 0; i < 400 && wr_ready !== 1'b1; i++) @(negedge mclk);
    if (i >= 400) begin
      errors++;
      end_of_test();
    end
    @(posedge mclk) wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk) wr_valid <= 1'b0;
    for (i = i; i < 800 && wr_pulse !== 1'b1; i++) @(negedge mclk);
    if (i >= 800) begin
      errors++;
      end_of_test();
    end
  endtask
  // hand-made frame on the second link, sclk period 125 ns
  task automatic raw(input logic [15:0] w, input int n);
    int i;
    #3 link2.sclk = 1'b1;
    for (i = 0; i < n; i++) begin
      #61 link2.sclk = 1'b0;
      link2.port_select_n = 1'b0;
      link2.serial_data_in = w[i];
      #64 link2.sclk = 1'b1;
    end
    #61 link2.sclk = 1'b0;
    link2.port_select_n = 1'b1;
    link2.serial_data_in = ~link2.serial_data_in;
    #400 @(posedge mclk) rd_addr <= 3'h2;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  // main sequence
  initial begin
    link2.sclk = 1'b0;
    link2.port_select_n = 1'b1;
    link2.serial_data_in = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 5'h00);
    for (int a = 0; a < 8; a++) wr(3'(a), 5'h1F - 5'(a * 3));
    for (int a = 0; a < 8; a++) rd(3'(a), 5'h1F - 5'(a * 3));
    wr(3'h7, 5'h00);
    rd(3'h7, 5'h00);
    raw({8'h1F, 4'h0, 3'h2, 1'b1}, 16);
    chk("read frame", 5'h00, rd_data2);
    raw({8'h1F, 4'h0, 3'h2, 1'b0}, 10);
    chk("abort", 5'h00, rd_data2);
    raw({8'h0A, 4'h0, 3'h2, 1'b0}, 16);
    chk("raw write", 5'h0A, rd_data2);
    chk("pulses", 5'h01, 5'(n_p2));
    end_of_test();
  end
  // count completed writes on the second device
  always @(posedge mclk) if (wr_pulse2 === 1'b1) n_p2 <= n_p2 + 1;
endmodule // tb_serial_control_port_write
